// file: adc_link_pkg.sv
// Shared constants for the converter serial port and its host controller
`default_nettype none
package adc_link_pkg;
  // Command byte layout
  localparam int unsigned CMD_BITS     = 8;
  localparam int unsigned CMD_READ_POS = 6;
  localparam int unsigned CMD_REG_LSB  = 4;
  // Register selects inside the converter
  typedef enum logic [1:0] {
    REG_STATUS = 2'h0,
    REG_MODE   = 2'h1,
    REG_FILTER = 2'h2,
    REG_DATA   = 2'h3
  } reg_sel_t;
  // Status byte bit positions
  localparam int unsigned STAT_RDY_POS = 7;
  localparam int unsigned STAT_ERR_POS = 6;
  localparam int unsigned STAT_WL_POS  = 2;
  // Mode register: reset value and power-down code
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam int unsigned MODE_MD_LSB = 6;
  localparam logic [1:0] MODE_MD_PD  = 2'h3;
  // Converter update period and early ready release
  localparam logic [15:0] UPDATE_CYCLES = 16'h07d0;
  localparam logic [15:0] GUARD_CYCLES  = 16'h0032;
  // Host serial clock half period in core cycles
  localparam logic [7:0] SCLK_HALF = 8'h08;
  // Host APB register offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATE  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_DATA   = 12'h00c;
  localparam logic [11:0] OFS_IRQ_ST = 12'h010;
  localparam logic [11:0] OFS_IRQ_CL = 12'h014;
  localparam logic [11:0] OFS_IRQ_EN = 12'h018;
  // Control register fields
  localparam int unsigned CTRL_GO_POS   = 0;
  localparam int unsigned CTRL_OP_LSB   = 1;
  localparam int unsigned CTRL_MODE_LSB = 8;
  typedef enum logic [1:0] {
    OP_STATUS = 2'h0,
    OP_DATA   = 2'h1,
    OP_MODE   = 2'h2
  } op_t;
  // Interrupt bits and reset values
  localparam int unsigned IRQ_DONE_POS = 0;
  localparam int unsigned IRQ_ERR_POS  = 1;
  localparam logic [1:0]  IRQ_RST      = 2'h0;
  localparam logic        PD_RST       = 1'h0;

  // Builds a command byte
  function automatic logic [7:0] cmd_byte(input logic rd, input reg_sel_t sel);
    logic [7:0] b;
    b = 8'h00;
    b[CMD_READ_POS] = rd;
    b[CMD_REG_LSB +: 2] = sel;
    return b;
  endfunction

  // Result word length for a variant
  function automatic logic [4:0] word_bits(input logic long_word);
    return long_word ? 5'h18 : 5'h10;
  endfunction
endpackage
`default_nettype wire

// file: adc_link_if.sv
// Serial link between converter port and host controller
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic cs_n;           // Chip select, low active
  logic sclk;           // Serial clock from host
  logic din;            // Serial data into converter
  logic dev_o;          // Converter drive value
  logic dev_oe;         // Converter drives shared pin
  logic dout_rdy_n;     // Shared data-out and ready wire
  logic ref_power_down; // Reference shutdown control

  // Pull-up when the converter lets go
  assign dout_rdy_n = dev_oe ? dev_o : 1'h1;

  modport dev (
    input  cs_n,
    input  sclk,
    input  din,
    output dev_o,
    output dev_oe,
    input  ref_power_down
  );
  modport host (
    output cs_n,
    output sclk,
    output din,
    input  dout_rdy_n,
    output ref_power_down
  );
endinterface
`default_nettype wire

// file: adc_conv_port.sv
// Converter end of the serial port: command decode, registers, shared pin
`timescale 1ns/1ps
`default_nettype none
module adc_conv_port #(
  parameter logic        WORD24        = 1'h1,
  parameter logic [15:0] UPDATE_CYCLES = adc_link_pkg::UPDATE_CYCLES,
  parameter logic [15:0] GUARD_CYCLES  = adc_link_pkg::GUARD_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  adc_link_if.dev          link,
  input  wire logic [23:0] sample_in,
  input  wire logic        conv_error,
  output logic             converting
);

  // Serial engine states
  typedef enum logic [3:0] {
    ST_CMD   = 4'h1,
    ST_LOAD  = 4'h2,
    ST_READ  = 4'h4,
    ST_WRITE = 4'h8
  } dev_state_t;

  logic [1:0] cs_sync_q;    // Chip select synchroniser
  logic [1:0] sclk_sync_q;  // Serial clock synchroniser
  logic [1:0] din_sync_q;   // Data in synchroniser
  logic       sclk_prev_q;  // Last synced clock level

  dev_state_t               state_q;   // Engine state
  logic [4:0]               bit_q;     // Bits in current phase
  logic [4:0]               len_q;     // Bits in read phase
  logic [7:0]               in_q;      // Incoming shift register
  logic [23:0]              out_q;     // Outgoing shift register
  adc_link_pkg::reg_sel_t   sel_q;     // Register being read
  logic [7:0]               mode_q;    // Mode register
  logic [23:0]              data_q;    // Result register
  logic                     rdy_n_q;   // Ready level, low when fresh
  logic [15:0]              upd_cnt_q; // Update period counter

  // Synced pin views, second flip-flop only
  wire logic cs_n_s = cs_sync_q[1];
  wire logic sclk_s = sclk_sync_q[1];
  wire logic din_s  = din_sync_q[1];

  // Edges of the host clock; gated bursts just pause them
  wire logic sclk_rise = sclk_s & ~sclk_prev_q;
  wire logic sclk_fall = ~sclk_s & sclk_prev_q;

  // Command byte as it completes, MSB first
  wire logic [7:0] cmd_now = {in_q[6:0], din_s};
  wire logic cmd_rd = cmd_now[adc_link_pkg::CMD_READ_POS];
  wire adc_link_pkg::reg_sel_t cmd_sel =
    adc_link_pkg::reg_sel_t'(cmd_now[adc_link_pkg::CMD_REG_LSB +: 2]);
  wire logic cmd_last = (bit_q == 5'(adc_link_pkg::CMD_BITS - 1));
  wire logic read_last = (bit_q == 5'(len_q - 5'h01));

  // Status byte: ready, error, fixed one, word length
  wire logic [7:0] status_byte = {rdy_n_q, conv_error, 2'h0, 1'h1,
                                  WORD24, 2'h0};

  // Value placed in the output shift register, left justified
  wire logic [23:0] load_val =
    (sel_q == adc_link_pkg::REG_DATA)   ? data_q :
    (sel_q == adc_link_pkg::REG_STATUS) ? {status_byte, 16'h0000} :
                                          {mode_q, 16'h0000};
  wire logic [4:0] load_len =
    (sel_q == adc_link_pkg::REG_DATA) ? adc_link_pkg::word_bits(WORD24)
                                      : 5'h08;

  // Result register busy with a read in progress
  wire logic reading_data = (sel_q == adc_link_pkg::REG_DATA) &
                            ((state_q == ST_LOAD) | (state_q == ST_READ));
  // Last bit of a result word taken by the host
  wire logic data_done = (state_q == ST_READ) & sclk_rise & read_last &
                         (sel_q == adc_link_pkg::REG_DATA);

  // Update timing
  wire logic upd_wrap  = converting & (upd_cnt_q == 16'(UPDATE_CYCLES - 16'h0001));
  wire logic upd_guard = converting & (upd_cnt_q == 16'(UPDATE_CYCLES - GUARD_CYCLES));

  // Converting unless mode asks for power down
  assign converting = (mode_q[adc_link_pkg::MODE_MD_LSB +: 2] != adc_link_pkg::MODE_MD_PD);

  // Shared pin, driven only while selected: shift data while reading, ready otherwise
  assign link.dev_oe = ~cs_n_s;
  assign link.dev_o  = (state_q == ST_READ) ? out_q[23] : rdy_n_q;

  // Pin synchronisers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cs_sync_q   <= 2'h3;
      sclk_sync_q <= 2'h3;
      din_sync_q  <= 2'h0;
      sclk_prev_q <= 1'h1;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], link.cs_n};
      sclk_sync_q <= {sclk_sync_q[0], link.sclk};
      din_sync_q  <= {din_sync_q[0], link.din};
      sclk_prev_q <= sclk_s;
    end
  end

  // Serial engine; host clock edges move it, deselect returns it to ST_CMD
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_CMD;
      bit_q   <= 5'h00;
      len_q   <= 5'h08;
      in_q    <= 8'h00;
      out_q   <= 24'h00_0000;
      sel_q   <= adc_link_pkg::REG_STATUS;
      mode_q  <= adc_link_pkg::MODE_RST;
    end else if (cs_n_s) begin
      // Deselected: drop any partial transfer
      state_q <= ST_CMD;
      bit_q   <= 5'h00;
    end else begin
      case (state_q)
        ST_CMD: begin
          // Collect command bits on rising edges
          if (sclk_rise) begin
            in_q  <= cmd_now;
            bit_q <= cmd_last ? 5'h00 : 5'(bit_q + 5'h01);
            if (cmd_last) begin
              sel_q <= cmd_sel;
              if (cmd_rd) begin
                state_q <= ST_LOAD;
              end else if (cmd_sel == adc_link_pkg::REG_MODE) begin
                state_q <= ST_WRITE;
              end else begin
                state_q <= ST_CMD;
              end
            end
          end
        end
        ST_LOAD: begin
          // First output bit appears on the next falling edge
          if (sclk_fall) begin
            out_q   <= load_val;
            len_q   <= load_len;
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          // Shift out on falling, count on rising
          if (sclk_fall) begin
            out_q <= {out_q[22:0], 1'h0};
          end
          if (sclk_rise) begin
            bit_q <= read_last ? 5'h00 : 5'(bit_q + 5'h01);
            if (read_last) begin
              state_q <= ST_CMD;
            end
          end
        end
        ST_WRITE: begin
          // Mode byte arrives MSB first
          if (sclk_rise) begin
            in_q  <= cmd_now;
            bit_q <= cmd_last ? 5'h00 : 5'(bit_q + 5'h01);
            if (cmd_last) begin
              mode_q  <= cmd_now;
              state_q <= ST_CMD;
            end
          end
        end
        default: begin
          state_q <= ST_CMD;
          bit_q   <= 5'h00;
        end
      endcase
    end
  end

  // Update period counter, runs while converting
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      upd_cnt_q <= 16'h0000;
    end else if (!converting || upd_wrap) begin
      upd_cnt_q <= 16'h0000;
    end else begin
      upd_cnt_q <= 16'(upd_cnt_q + 16'h0001);
    end
  end

  // Result register and ready level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_q  <= 24'h00_0000;
      rdy_n_q <= 1'h1;
    end else begin
      // Word read out, or update close: release ready
      if (data_done || upd_guard) begin
        rdy_n_q <= 1'h1;
      end
      // New result, dropped for this update while the host is reading the result register
      if (upd_wrap && !reading_data) begin
        data_q  <= WORD24 ? sample_in : {sample_in[23:8], 8'h00};
        rdy_n_q <= 1'h0;
      end
    end
  end

endmodule
`default_nettype wire

// file: adc_host_ctrl.sv
// Host end of the serial port: APB registers, clock divider, transfer engine
`timescale 1ns/1ps
`default_nettype none
module adc_host_ctrl #(
  parameter logic [7:0] SCLK_HALF = adc_link_pkg::SCLK_HALF
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  adc_link_if.host         link
);

  // Transfer engine states
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_WAIT  = 4'h2,
    H_SHIFT = 4'h4,
    H_END   = 4'h8
  } host_state_t;

  host_state_t       state_q;     // Engine state
  adc_link_pkg::op_t op_q;        // Operation in flight
  logic [7:0]        div_q;       // Half period divider
  logic              sclk_q;      // Serial clock out
  logic              cs_n_q;      // Chip select out
  logic              din_q;       // Serial data out
  logic [31:0]       tx_q;        // Outgoing bits
  logic [23:0]       rx_q;        // Incoming bits
  logic [5:0]        bit_q;       // Rising edges so far
  logic [5:0]        total_q;     // Rising edges in transfer
  logic              boot_done_q; // Start-up status read finished
  logic              word24_q;    // Long result words expected
  logic              pd_q;        // Reference power down
  logic [7:0]        mode_q;      // Mode byte being written
  logic [7:0]        status_q;    // Last status byte
  logic [23:0]       data_q;      // Last result
  logic [1:0]        irq_st_q;    // Sticky events
  logic [1:0]        irq_en_q;    // Event enables
  logic [1:0]        dout_sync_q; // Shared pin synchroniser

  // APB decode
  wire logic acc    = psel & penable;
  wire logic wr     = acc & pwrite;
  wire logic hit_ct = (paddr == adc_link_pkg::OFS_CTRL);
  wire logic hit_sr = (paddr == adc_link_pkg::OFS_STATE);
  wire logic hit_st = (paddr == adc_link_pkg::OFS_STATUS);
  wire logic hit_dt = (paddr == adc_link_pkg::OFS_DATA);
  wire logic hit_is = (paddr == adc_link_pkg::OFS_IRQ_ST);
  wire logic hit_ic = (paddr == adc_link_pkg::OFS_IRQ_CL);
  wire logic hit_ie = (paddr == adc_link_pkg::OFS_IRQ_EN);
  wire logic hit    = hit_ct | hit_sr | hit_st | hit_dt | hit_is | hit_ic | hit_ie;

  // Engine inputs
  wire logic dout_s = dout_sync_q[1];
  wire logic idle   = (state_q == H_IDLE);
  wire logic tick   = (div_q == 8'(SCLK_HALF - 8'h01));
  wire logic boot_go = idle & ~boot_done_q;
  wire logic user_go = wr & hit_ct & pwdata[adc_link_pkg::CTRL_GO_POS] & idle & boot_done_q;
  wire logic start  = boot_go | user_go;
  wire adc_link_pkg::op_t req_op = boot_go ? adc_link_pkg::OP_STATUS :
    adc_link_pkg::op_t'(pwdata[adc_link_pkg::CTRL_OP_LSB +: 2]);
  wire logic [7:0] req_mode = pwdata[adc_link_pkg::CTRL_MODE_LSB +: 8];
  wire logic [7:0] req_cmd =
    (req_op == adc_link_pkg::OP_MODE) ? adc_link_pkg::cmd_byte(1'h0, adc_link_pkg::REG_MODE) :
    (req_op == adc_link_pkg::OP_DATA) ? adc_link_pkg::cmd_byte(1'h1, adc_link_pkg::REG_DATA) :
                                        adc_link_pkg::cmd_byte(1'h1, adc_link_pkg::REG_STATUS);
  wire logic [4:0] req_len = (req_op == adc_link_pkg::OP_DATA) ?
    adc_link_pkg::word_bits(word24_q) : 5'h08;
  wire logic last_rise = tick & ~sclk_q & (bit_q == 6'(total_q - 6'h01));
  wire logic ev_done = (state_q == H_END);
  wire logic ev_err  = ev_done & (op_q == adc_link_pkg::OP_STATUS) &
                       rx_q[adc_link_pkg::STAT_ERR_POS];
  wire logic [1:0] ev_vec = {ev_err, ev_done};
  wire logic [1:0] irq_clr = (wr & hit_ic) ? pwdata[1:0] : 2'h0;

  // APB answers at once
  assign pready  = 1'h1;
  assign pslverr = acc & ~hit;
  assign prdata  =
    hit_ct ? {16'h0000, mode_q, 8'h00} :
    hit_sr ? {28'h000_0000, pd_q, word24_q, boot_done_q, ~idle} :
    hit_st ? {24'h00_0000, status_q} :
    hit_dt ? {8'h00, data_q} :
    hit_is ? {30'h0000_0000, irq_st_q} :
    hit_ie ? {30'h0000_0000, irq_en_q} : 32'h0000_0000;
  assign irq = |(irq_st_q & irq_en_q);

  // Link pins, all from flip-flops
  assign link.cs_n           = cs_n_q;
  assign link.sclk           = sclk_q;
  assign link.din            = din_q;
  assign link.ref_power_down = pd_q;

  // Shared pin synchroniser
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dout_sync_q <= 2'h3;
    end else begin
      dout_sync_q <= {dout_sync_q[0], link.dout_rdy_n};
    end
  end

  // Interrupt status, enable; a new event beats a clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_st_q <= adc_link_pkg::IRQ_RST;
      irq_en_q <= adc_link_pkg::IRQ_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | ev_vec;
      if (wr && hit_ie) begin
        irq_en_q <= pwdata[1:0];
      end
    end
  end

  // Serial clock divider, restarted at each transfer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 8'h00;
    end else if (start || tick || state_q != H_SHIFT) begin
      div_q <= 8'h00;
    end else begin
      div_q <= 8'(div_q + 8'h01);
    end
  end

  // Transfer engine
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= H_IDLE;
      op_q        <= adc_link_pkg::OP_STATUS;
      sclk_q      <= 1'h1;
      cs_n_q      <= 1'h1;
      din_q       <= 1'h0;
      tx_q        <= 32'h0000_0000;
      rx_q        <= 24'h00_0000;
      bit_q       <= 6'h00;
      total_q     <= 6'h10;
      boot_done_q <= 1'h0;
      word24_q    <= 1'h0;
      pd_q        <= adc_link_pkg::PD_RST;
      mode_q      <= adc_link_pkg::MODE_RST;
      status_q    <= 8'h00;
      data_q      <= 24'h00_0000;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (start) begin
            op_q    <= req_op;
            tx_q    <= {req_cmd, req_mode, 16'h0000};
            total_q <= 6'(6'h08 + {1'h0, req_len});
            bit_q   <= 6'h00;
            cs_n_q  <= 1'h0;
            if (req_op == adc_link_pkg::OP_MODE) begin
              mode_q <= req_mode;
            end
            state_q <= (req_op == adc_link_pkg::OP_DATA) ? H_WAIT : H_SHIFT;
          end
        end
        H_WAIT: begin
          // Read only once the shared pin shows ready low
          if (!dout_s) begin
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick && sclk_q) begin
            // Falling edge: present next bit, MSB first
            sclk_q <= 1'h0;
            din_q  <= tx_q[31];
            tx_q   <= {tx_q[30:0], 1'h0};
          end else if (tick) begin
            // Rising edge: sample the converter
            sclk_q <= 1'h1;
            rx_q   <= {rx_q[22:0], dout_s};
            bit_q  <= 6'(bit_q + 6'h01);
            if (last_rise) begin
              state_q <= H_END;
            end
          end
        end
        H_END: begin
          cs_n_q  <= 1'h1;
          din_q   <= 1'h0;
          state_q <= H_IDLE;
          case (op_q)
            adc_link_pkg::OP_STATUS: begin
              status_q <= rx_q[7:0];
              if (!boot_done_q) begin
                word24_q    <= rx_q[adc_link_pkg::STAT_WL_POS];
                boot_done_q <= 1'h1;
              end
            end
            adc_link_pkg::OP_DATA: begin
              data_q <= word24_q ? rx_q : {8'h00, rx_q[15:0]};
            end
            default: begin
              // Reference off whenever conversion stops
              pd_q <= (mode_q[adc_link_pkg::MODE_MD_LSB +: 2] == adc_link_pkg::MODE_MD_PD);
            end
          endcase
        end
        default: begin
          state_q <= H_IDLE;
          cs_n_q  <= 1'h1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: adc_link_monitor.sv
// Concurrent checks on the serial link between host controller and converter
`timescale 1ns/1ps
`default_nettype none
module adc_link_monitor (
  input wire logic core_clk,      // Core clock
  input wire logic nrst,          // Async reset, low active
  input wire logic cs_n,          // Chip select, low active
  input wire logic sclk,          // Serial clock from host
  input wire logic din,           // Serial data into converter
  input wire logic dev_o,         // Converter drive value
  input wire logic dev_oe,        // Converter drives shared pin
  input wire logic dout_rdy_n,    // Resolved shared pin
  input wire logic ref_power_down // Reference shutdown
);
  logic       sclk_q; // Serial clock one cycle back
  logic [5:0] cnt_q;  // Rising edges seen in this frame
  logic       rd_q;   // Read bit of the command byte
  wire        rise_w; // Serial clock rising this cycle
  assign rise_w = sclk & ~sclk_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Edge detect, frame bit counter, command read bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b1;
      cnt_q  <= 6'h00;
      rd_q   <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cnt_q  <= cs_n ? 6'h00 : cnt_q + {5'h00, rise_w};
      rd_q   <= (rise_w && cnt_q == 6'h01) ? din : rd_q;
    end
  end
  property p_desel;
    cs_n [*4] |-> !dev_oe && dout_rdy_n;
  endproperty
  a_desel: assert property (p_desel) else $error("pin driven while deselected");
  property p_sel;
    !cs_n [*4] |-> dev_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("pin not driven while selected");
  property p_cs_edge;
    $changed(cs_n) |-> sclk && $past(sclk);
  endproperty
  a_cs_edge: assert property (p_cs_edge) else $error("select moved with clock low");
  property p_sclk_idle;
    cs_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock runs outside frame");
  property p_sclk_low;
    $fell(sclk) |-> (!sclk) [*8] ##1 sclk;
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("serial clock low phase wrong");
  property p_din_stable;
    !cs_n && $past(!cs_n) && sclk && $past(sclk) |-> $stable(din);
  endproperty
  a_din_stable: assert property (p_din_stable) else $error("data in moved while clock high");
  property p_dout_hold;
    !cs_n && rd_q && cnt_q >= 6'h08 && rise_w |-> $stable(dev_o) [*3];
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("data out moved at sampling edge");
  property p_frame_len;
    $rose(cs_n) |-> cnt_q == 6'h10 || cnt_q == 6'h20;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_pd_idle;
    $changed(ref_power_down) |-> cs_n;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("shutdown moved inside a frame");
  c_data: cover property ($rose(cs_n) && cnt_q == 6'h20);
  c_pd: cover property ($rose(ref_power_down));
  c_rdy: cover property (!cs_n && dev_oe && !dout_rdy_n);
endmodule
`default_nettype wire

// file: adc_serial_readout_port_tb_top.sv
// Testbench joining host controller and converter over the serial link
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_port_tb_top;
  logic        core_clk, nrst;         // Clock and async reset
  logic [11:0] paddr;                  // APB address
  logic        psel, penable, pwrite;  // APB controls
  logic [31:0] pwdata, prdata, rd;     // APB data and last read
  logic        pready, pslverr, err;   // APB answer and last error
  logic        irq, converting;        // Interrupt, converter running
  logic [23:0] sample_in;              // Converter sample
  logic        conv_error;             // Converter fault
  int          error_cnt, tests_run;   // Mismatches and comparisons
  // Free running 100 MHz clock
  always #5 core_clk = ~core_clk;
  adc_link_if adc_link_if_i ();
  adc_conv_port #(.WORD24(1'h1), .UPDATE_CYCLES(16'h03e8), .GUARD_CYCLES(16'h0014)) adc_conv_port_i (
    .core_clk(core_clk), .nrst(nrst), .link(adc_link_if_i), .sample_in(sample_in),
    .conv_error(conv_error), .converting(converting));
  adc_host_ctrl adc_host_ctrl_i (.core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(adc_link_if_i));
  adc_link_monitor adc_link_monitor_i (.core_clk(core_clk), .nrst(nrst), .cs_n(adc_link_if_i.cs_n),
    .sclk(adc_link_if_i.sclk), .din(adc_link_if_i.din), .dev_o(adc_link_if_i.dev_o),
    .dev_oe(adc_link_if_i.dev_oe), .dout_rdy_n(adc_link_if_i.dout_rdy_n),
    .ref_power_down(adc_link_if_i.ref_power_down));
  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Compare and report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, answer taken at the edge with pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    psel    <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, {31'h0, pready});
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll a STATE bit until it holds the wanted value
  task automatic wait_bit(input int pos, input logic val);
    int n;
    n = 0;
    do begin
      apb(1'b0, adc_link_pkg::OFS_STATE, 32'h0000_0000);
      n++;
    end while (rd[pos] !== val && n < 3000);
    if (rd[pos] !== val) begin
      chk("state_wait", {31'h0, val}, {31'h0, rd[pos]});
      conclude();
    end
  endtask
  // Start a link operation and wait until idle
  task automatic run(input adc_link_pkg::op_t op, input logic [7:0] mode);
    apb(1'b1, adc_link_pkg::OFS_CTRL, {16'h0000, mode, 5'h00, op, 1'b1});
    wait_bit(0, 1'b0);
    // Converter applies the last bit a few cycles after the host goes idle
    repeat (4) @(posedge core_clk);
  endtask
  // Interrupt line after the last write settled
  task automatic irq_is(input logic exp);
    @(posedge core_clk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  // Main sequence
  initial begin
    error_cnt = 0;
    tests_run = 0;
    core_clk = 1'b0;
    nrst = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    sample_in = 24'ha5_c31e;
    conv_error = 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    wait_bit(1, 1'b1);
    chk("word24", 32'h0000_0001, {31'h0, rd[2]});
    apb(1'b0, adc_link_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status_fixed", 32'h0000_000c, rd & 32'h0000_007f);
    apb(1'b1, adc_link_pkg::OFS_STATUS, 32'h0000_00ff);
    apb(1'b0, adc_link_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status_ro", 32'h0000_000c, rd & 32'h0000_007f);
    apb(1'b0, adc_link_pkg::OFS_IRQ_EN, 32'h0000_0000);
    chk("irq_en_rst", 32'h0000_0000, rd);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, err});
    irq_is(1'b0);
    apb(1'b1, adc_link_pkg::OFS_IRQ_EN, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, adc_link_pkg::OFS_IRQ_CL, 32'h0000_0001);
    irq_is(1'b0);
    run(adc_link_pkg::OP_DATA, 8'h00);
    apb(1'b0, adc_link_pkg::OFS_DATA, 32'h0000_0000);
    chk("data", 32'h00a5_c31e, rd);
    run(adc_link_pkg::OP_STATUS, 8'h00);
    apb(1'b0, adc_link_pkg::OFS_STATUS, 32'h0000_0000);
    chk("ready_after_read", 32'h0000_0080, rd & 32'h0000_0080);
    run(adc_link_pkg::OP_MODE, 8'hc0);
    chk("pd_on", 32'h0000_0008, {28'h0, rd[3], 2'h0, converting});
    chk("pd_pin", 32'h0000_0001, {31'h0, adc_link_if_i.ref_power_down});
    run(adc_link_pkg::OP_MODE, 8'h00);
    chk("pd_off", 32'h0000_0001, {28'h0, rd[3], 2'h0, converting});
    conv_error <= 1'b1;
    apb(1'b1, adc_link_pkg::OFS_IRQ_CL, 32'h0000_0003);
    run(adc_link_pkg::OP_STATUS, 8'h00);
    apb(1'b0, adc_link_pkg::OFS_STATUS, 32'h0000_0000);
    chk("err_flag", 32'h0000_0040, rd & 32'h0000_0040);
    apb(1'b1, adc_link_pkg::OFS_IRQ_CL, 32'h0000_0001);
    apb(1'b0, adc_link_pkg::OFS_IRQ_ST, 32'h0000_0000);
    chk("irq_st_err", 32'h0000_0002, rd);
    irq_is(1'b0);
    apb(1'b1, adc_link_pkg::OFS_IRQ_EN, 32'h0000_0002);
    irq_is(1'b1);
    apb(1'b1, adc_link_pkg::OFS_IRQ_CL, 32'h0000_0003);
    irq_is(1'b0);
    conclude();
  end
endmodule
`default_nettype wire
